// *** pct_trace_out.sv ***
`timescale 1ns/10ps
module pct_trace_out #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // retirement from the core, one core clock each
  input wire logic pipe0_retire_in,
  input wire logic pipe1_retire_in,
  input wire logic jump_retire_in,
  input wire logic ind_target_retire_in,
  input wire logic [ADDR_W-1:0] target_addr_in,
  // exceptions from the core
  input wire logic exc_taken_in,
  input wire logic [pct_pkg::NIB_W-1:0] exc_code_in,
  input wire logic exc_by_jump_in,
  input wire logic exc_target_retire_in,
  // trace pins
  output logic bus_clock_out,
  output logic pipe0_retire_phase_a_n_out,
  output logic pipe1_retire_phase_a_n_out,
  output logic pipe0_retire_phase_b_n_out,
  output logic pipe1_retire_phase_b_n_out,
  output logic jump_retired_phase_a_n_out,
  output logic jump_retired_phase_b_n_out,
  output logic target_strobe_n_out,
  output logic [pct_pkg::NIB_W-1:0] target_nibble_bus_out
);
  import pct_pkg::*;

  initial begin
    if (ADDR_BEATS * CPU_CYC_PER_BUS != TARGET_CPU_CYCLES)
      $error("pct_trace_out: beat timing inconsistent");
  end

  logic phase_q;
  logic a_p0_q, a_p1_q, a_jr_q, a_jt_q, a_et_q, a_kill_q;
  logic [ADDR_W-1:0] a_addr_q;
  logic [NIB_W-1:0] a_code_q;
  logic [NIB_W-1:0] pend_code_q;
  logic blk_q;
  logic code_pend_q;
  logic [NIB_W-1:0] code_q;
  logic [ADDR_W-1:0] ld_addr_q;
  logic kill_now, blk_now, jt_now, kill_win;
  logic [NIB_W-1:0] cur_code;
  logic [NIB_W-1:0] typ;
  logic ev_any, sel_exc;
  logic [NIB_W-1:0] sel_code;
  logic [ADDR_W-1:0] sel_addr;
  logic ser_load, ser_abort, ser_step, ser_busy;
  logic [NIB_W-1:0] ser_nib;

  // ----------------------------------------------------------------
  // phase and bus clock: a bus cycle is phase A then phase B
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      phase_q <= PHASE_A;
      bus_clock_out <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
      bus_clock_out <= (phase_q == PHASE_B);
    end
  end

  // ----------------------------------------------------------------
  // exception bookkeeping
  // ----------------------------------------------------------------
  // a faulting jump or its neighbours never show as a jump
  assign kill_now = exc_taken_in & exc_by_jump_in;
  assign blk_now = blk_q | kill_now;
  assign jt_now = ind_target_retire_in & ~blk_now;
  assign cur_code = exc_taken_in ? exc_code_in : pend_code_q;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pend_code_q <= CODE_RST;
      blk_q <= 1'b0;
    end else begin
      // a later exception overwrites the unreported code
      if (exc_taken_in) begin
        pend_code_q <= exc_code_in;
      end
      if (kill_now) begin
        blk_q <= 1'b1;
      end else if (exc_target_retire_in) begin
        blk_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // phase A capture, reported together with phase B
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      a_p0_q <= 1'b0;
      a_p1_q <= 1'b0;
      a_jr_q <= 1'b0;
      a_jt_q <= 1'b0;
      a_et_q <= 1'b0;
      a_kill_q <= 1'b0;
      a_addr_q <= '0;
      a_code_q <= CODE_RST;
    end else if (phase_q == PHASE_A) begin
      a_p0_q <= pipe0_retire_in;
      a_p1_q <= pipe1_retire_in;
      a_jr_q <= jump_retire_in;
      a_jt_q <= jt_now;
      a_et_q <= exc_target_retire_in;
      a_kill_q <= kill_now;
      a_addr_q <= target_addr_in;
      a_code_q <= cur_code;
    end
  end

  // ----------------------------------------------------------------
  // window decode, valid in phase B
  // ----------------------------------------------------------------
  assign kill_win = a_kill_q | kill_now;
  always_comb begin
    typ = '0;
    typ[TYP_JUMP_A] = a_jt_q & ~kill_now;
    typ[TYP_EXC_A] = a_et_q;
    typ[TYP_JUMP_B] = jt_now;
    typ[TYP_EXC_B] = exc_target_retire_in;
  end
  assign ev_any = |typ;

  // the later event owns the data cycles that follow
  always_comb begin
    sel_exc = 1'b0;
    sel_code = cur_code;
    sel_addr = target_addr_in;
    if (typ[TYP_EXC_B]) begin
      sel_exc = 1'b1;
    end else if (typ[TYP_JUMP_B]) begin
      sel_exc = 1'b0;
    end else if (typ[TYP_EXC_A]) begin
      sel_exc = 1'b1;
      sel_code = a_code_q;
    end else begin
      sel_addr = a_addr_q;
    end
  end

  assign ser_load = (phase_q == PHASE_B) & ev_any & ~sel_exc;
  assign ser_abort = (phase_q == PHASE_B) & ev_any & sel_exc;
  assign ser_step = (phase_q == PHASE_B) & ~ev_any & ~code_pend_q & ser_busy;

  pct_nibble_ser #(
    .ADDR_W(ADDR_W),
    .BEATS(ADDR_BEATS)
  ) u_ser (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .load_in(ser_load),
    .abort_in(ser_abort),
    .step_in(ser_step),
    .addr_in(sel_addr),
    .busy_out(ser_busy),
    .nibble_out(ser_nib)
  );

  // ----------------------------------------------------------------
  // retire pins, updated once a bus cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pipe0_retire_phase_a_n_out <= OUT_IDLE_N;
      pipe1_retire_phase_a_n_out <= OUT_IDLE_N;
      pipe0_retire_phase_b_n_out <= OUT_IDLE_N;
      pipe1_retire_phase_b_n_out <= OUT_IDLE_N;
      jump_retired_phase_a_n_out <= OUT_IDLE_N;
      jump_retired_phase_b_n_out <= OUT_IDLE_N;
    end else if (phase_q == PHASE_B) begin
      // each pipe drives its own pin, so dual retirement asserts both
      pipe0_retire_phase_a_n_out <= ~a_p0_q;
      pipe1_retire_phase_a_n_out <= ~a_p1_q;
      pipe0_retire_phase_b_n_out <= ~pipe0_retire_in;
      pipe1_retire_phase_b_n_out <= ~pipe1_retire_in;
      jump_retired_phase_a_n_out <= ~(a_jr_q & ~kill_win);
      jump_retired_phase_b_n_out <= ~(jump_retire_in & ~kill_win);
    end
  end

  // ----------------------------------------------------------------
  // strobe and nibble bus
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      target_strobe_n_out <= OUT_IDLE_N;
      target_nibble_bus_out <= NIB_IDLE;
      code_pend_q <= 1'b0;
      code_q <= CODE_RST;
      ld_addr_q <= '0;
    end else if (phase_q == PHASE_B) begin
      if (ev_any) begin
        // a new target always preempts whatever is on the bus
        target_strobe_n_out <= 1'b0;
        target_nibble_bus_out <= ~typ;
        code_pend_q <= sel_exc;
        if (sel_exc) begin
          code_q <= sel_code;
        end else begin
          ld_addr_q <= sel_addr;
        end
      end else if (code_pend_q) begin
        target_strobe_n_out <= 1'b1;
        target_nibble_bus_out <= code_q;
        code_pend_q <= 1'b0;
      end else if (ser_busy) begin
        target_strobe_n_out <= 1'b1;
        target_nibble_bus_out <= ser_nib;
      end else begin
        target_strobe_n_out <= 1'b1;
        target_nibble_bus_out <= NIB_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  a_dual_retire: assert property (
    phase_q && pipe0_retire_in && pipe1_retire_in |=>
      !pipe0_retire_phase_b_n_out && !pipe1_retire_phase_b_n_out)
    else $error("dual retirement not shown on both pipes");
  a_jump_restart: assert property (
    phase_q && ev_any && !sel_exc && ser_busy |=> !target_strobe_n_out ##2
      (!target_strobe_n_out || target_nibble_bus_out == ld_addr_q[ADDR_LSB +: NIB_W]))
    else $error("new jump target did not restart address output");
  a_exc_abort: assert property (
    phase_q && ev_any && sel_exc && ser_busy |=> (!target_strobe_n_out && !ser_busy) ##2
      (!target_strobe_n_out || target_nibble_bus_out == code_q))
    else $error("exception did not replace address output");
  a_jump_hidden: assert property (
    phase_q && kill_win |=> jump_retired_phase_a_n_out && jump_retired_phase_b_n_out)
    else $error("jump shown for a faulting jump");
  a_latest_code: assert property (
    (exc_taken_in && !phase_q && !exc_target_retire_in) ##1
      (exc_target_retire_in && !exc_taken_in) |=>
      !target_strobe_n_out && code_q == $past(exc_code_in, 2))
    else $error("reported code is not the latest exception");
  a_retire_low: assert property (
    phase_q |=> pipe1_retire_phase_b_n_out == !$past(pipe1_retire_in) &&
      pipe0_retire_phase_a_n_out == !$past(a_p0_q))
    else $error("retire pin level wrong");
  a_strobe_hold: assert property (
    phase_q && ev_any |=> !target_strobe_n_out [*2])
    else $error("target strobe not held for a bus cycle");
  a_type_bits: assert property (
    phase_q && ev_any |=> target_nibble_bus_out == ~$past(typ))
    else $error("type nibble wrong");
endmodule

// *** pct_nibble_ser.sv ***
// How it works
// - two pipes retiring in one phase assert both retire outputs, one pin per pipe.
// - new indirect-jump target aborts an address transfer, strobes, then sends new address.
// - exception during an address transfer aborts it, strobes, then presents vector code.
// - exception raised by jump, delay slot or target hides the jump entirely.
// - back-to-back exceptions report only the second handler's vector code.
// - retire and jump outputs are active low; high means nothing retired.
// - target strobe with type nibble first, then address or code on the nibble bus.
// - type bits: 0 jump A, 1 exception A, 2 jump B, 3 exception B.
// - target address goes out in eight nibbles, bits 5:2 first.
`timescale 1ns/10ps
package pct_pkg;
  // ----------------------------------------------------------------
  // bus shape and timing
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_BEATS = 8;
  localparam int CPU_CYC_PER_BUS = 2;
  localparam int TARGET_CPU_CYCLES = 16;
  localparam logic PHASE_A = 1'b0;
  localparam logic PHASE_B = 1'b1;
  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic OUT_IDLE_N = 1'b1;
  localparam logic [3:0] NIB_IDLE = 4'h0;
  localparam logic [3:0] CODE_RST = 4'h0;
  // ----------------------------------------------------------------
  // type nibble bit positions
  // ----------------------------------------------------------------
  localparam int TYP_JUMP_A = 0;
  localparam int TYP_EXC_A = 1;
  localparam int TYP_JUMP_B = 2;
  localparam int TYP_EXC_B = 3;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SEND = 2'b10
  } pct_ser_st_t;
endpackage

module pct_nibble_ser #(
  parameter int ADDR_W = 32,
  parameter int BEATS = pct_pkg::ADDR_BEATS
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // control
  input wire logic load_in,
  input wire logic abort_in,
  input wire logic step_in,
  input wire logic [ADDR_W-1:0] addr_in,
  // status
  output logic busy_out,
  output logic [pct_pkg::NIB_W-1:0] nibble_out
);
  import pct_pkg::*;
  localparam int SH_W = BEATS * NIB_W;
  localparam int CNT_W = $clog2(BEATS) + 1;
  localparam logic [CNT_W-1:0] LAST_BEAT = CNT_W'(BEATS - 1);

  initial begin
    if (ADDR_W < ADDR_LSB + NIB_W || BEATS < 1)
      $error("pct_nibble_ser: unusable width or beat count");
  end

  pct_ser_st_t st_q;
  logic [SH_W-1:0] sh_q;
  logic [CNT_W-1:0] cnt_q;
  logic [NIB_W-1:0] first_nib;

  assign first_nib = addr_in[ADDR_LSB +: NIB_W];
  assign busy_out = (st_q == SER_SEND);
  assign nibble_out = sh_q[NIB_W-1:0];

  // ----------------------------------------------------------------
  // shifter: load wins over abort and step
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_q <= SER_IDLE;
      sh_q <= '0;
      cnt_q <= '0;
    end else if (load_in) begin
      st_q <= SER_SEND;
      sh_q <= SH_W'(addr_in >> ADDR_LSB);
      cnt_q <= '0;
    end else begin
      case (st_q)
        SER_SEND: begin
          if (abort_in) begin
            st_q <= SER_IDLE;
          end else if (step_in) begin
            sh_q <= sh_q >> NIB_W;
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == LAST_BEAT) begin
              st_q <= SER_IDLE;
            end
          end
        end
        default: begin
          st_q <= SER_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  a_first_nibble: assert property (load_in |=> nibble_out == $past(first_nib))
    else $error("first address nibble is not bits 5:2");
  a_eight_beats: assert property (
    busy_out && step_in && !load_in && !abort_in && cnt_q == LAST_BEAT |=> !busy_out)
    else $error("address transfer did not end after its last beat");
endmodule

// *** pct_trace_probe.sv ***
`timescale 1ns/10ps
module pct_trace_probe (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // trace pins: retire and jump bits, then strobe and nibble
  input wire logic bus_clock_in,
  input wire logic [10:0] trace_in,
  // last captured bus cycle
  output logic [10:0] rec_out
);
  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // sample one edge after the update, so every pin has stood a full cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rec_out <= 11'h7f0;
    end else if (bus_clock_in) begin
      rec_out <= trace_in;
    end
  end
endmodule

// *** tb_pct_trace_out.sv ***
`timescale 1ns/10ps
module tb_pct_trace_out;
  import pct_pkg::*;
  typedef struct packed {
    logic [6:0] a;
    logic [6:0] b;
    logic [3:0] code;
    logic [10:0] e0;
    logic [10:0] e1;
  } pct_row_t;
  // control bits: pipe0, pipe1, jump, target, exc, by jump, handler retire
  localparam logic [6:0] P0 = 7'h40, P1 = 7'h20, JP = 7'h10, IND = 7'h08;
  localparam logic [6:0] EXC = 7'h04, BYJ = 7'h02, ETR = 7'h01;
  localparam logic [10:0] IDLE = 11'h7f0;
  localparam logic [31:0] AX = 32'h1234_5678;
  localparam logic [31:0] AY = 32'h9abc_def0;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [6:0] ctl = 7'h00;
  logic [3:0] code = 4'h0;
  logic [31:0] addr = 32'h0;
  logic bus_clk;
  wire [10:0] tr;
  logic [10:0] rec;
  int num_errors = 0;
  int num_checks = 0;
  pct_row_t rows [9];
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  pct_trace_out #(.ADDR_W(32)) DUT (
    .mclk_in(mclk_in), .srst_in(srst_in),
    .pipe0_retire_in(ctl[6]), .pipe1_retire_in(ctl[5]), .jump_retire_in(ctl[4]),
    .ind_target_retire_in(ctl[3]), .target_addr_in(addr), .exc_taken_in(ctl[2]),
    .exc_code_in(code), .exc_by_jump_in(ctl[1]), .exc_target_retire_in(ctl[0]),
    .bus_clock_out(bus_clk),
    .pipe0_retire_phase_a_n_out(tr[10]), .pipe1_retire_phase_a_n_out(tr[9]),
    .pipe0_retire_phase_b_n_out(tr[8]), .pipe1_retire_phase_b_n_out(tr[7]),
    .jump_retired_phase_a_n_out(tr[6]), .jump_retired_phase_b_n_out(tr[5]),
    .target_strobe_n_out(tr[4]), .target_nibble_bus_out(tr[3:0]));
  pct_trace_probe probe (.mclk_in(mclk_in), .srst_in(srst_in), .bus_clock_in(bus_clk),
    .trace_in(tr), .rec_out(rec));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] rec_of(input logic [5:0] act, input logic strb,
                                         input logic [3:0] n);
    return {~act, ~strb, n};
  endfunction
  // upper two beat bits are zero for a 32-bit target
  function automatic logic [3:0] nib(input logic [31:0] a, input int k);
    logic [33:0] w;
    w = {2'b00, a} >> (2 + 4 * k);
    return w[3:0];
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic drive(input logic [6:0] c, input logic [3:0] k, input logic [31:0] a);
    @(posedge mclk_in);
    ctl <= c;
    code <= k;
    addr <= a;
  endtask
  // one bus cycle: phase a values, phase b values, then quiet
  task automatic window(input logic [6:0] ca, input logic [6:0] cb, input logic [3:0] k,
                        input logic [31:0] a);
    drive(ca, k, a);
    drive(cb, k, a);
    drive(7'h00, k, a);
  endtask
  task automatic look(input int n, input logic [10:0] exp);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
    check(rec, exp);
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  // tests take under two hundred cycles
  initial begin
    repeat (3000) @(posedge mclk_in);
    num_errors++;
    $display("watchdog expired");
    test_done();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rows = '{
      '{P0 | P1, P0, 4'h0, rec_of(6'h38, 0, 4'h0), IDLE},
      '{JP | P1, P1 | JP, 4'h0, rec_of(6'h17, 0, 4'h0), IDLE},
      '{EXC, ETR | P1, 4'h9, rec_of(6'h04, 1, 4'h7), rec_of(0, 0, 4'h9)},
      '{EXC, 7'h00, 4'h3, IDLE, IDLE},
      '{ETR | P0, 7'h00, 4'h3, rec_of(6'h20, 1, 4'hd), rec_of(0, 0, 4'h3)},
      '{EXC, 7'h00, 4'he, IDLE, IDLE},
      '{IND, ETR, 4'he, rec_of(0, 1, 4'h6), rec_of(0, 0, 4'he)},
      '{7'h00, IND | P0, 4'h0, rec_of(6'h08, 1, 4'hb), rec_of(0, 0, nib(AX, 0))},
      '{ETR, IND, 4'h0, rec_of(0, 1, 4'h9), rec_of(0, 0, nib(AX, 0))}};
    repeat (20) @(posedge mclk_in);
    @(negedge mclk_in);
    check(tr, IDLE);
    check({10'h0, bus_clk}, 11'h0);
    @(posedge mclk_in);
    srst_in <= 1'b0;
    $display("test reset done");
    repeat (4) @(posedge mclk_in);
    do @(negedge mclk_in); while (bus_clk !== 1'b1);
    @(posedge mclk_in);
    foreach (rows[i]) begin
      window(rows[i].a, rows[i].b, rows[i].code, AX);
      look(1, rows[i].e0);
      look(2, rows[i].e1);
    end
    $display("test table done");
    // the last row left a target transfer running
    for (int k = 1; k < 8; k++) begin
      look(2, rec_of(0, 0, nib(AX, k)));
    end
    look(2, IDLE);
    $display("test address beats done");
    window(7'h00, IND, 4'h0, AX);
    look(1, rec_of(0, 1, 4'hb));
    look(2, rec_of(0, 0, nib(AX, 0)));
    look(2, rec_of(0, 0, nib(AX, 1)));
    window(IND, 7'h00, 4'h0, AY);
    look(1, rec_of(0, 1, 4'he));
    look(2, rec_of(0, 0, nib(AY, 0)));
    look(2, rec_of(0, 0, nib(AY, 1)));
    $display("test jump preempt done");
    window(EXC, ETR, 4'h5, AY);
    look(1, rec_of(0, 1, 4'h7));
    look(2, rec_of(0, 0, 4'h5));
    look(2, IDLE);
    $display("test exception preempt done");
    window(EXC | BYJ | P0, JP, 4'h6, AX);
    look(1, rec_of(6'h20, 0, 4'h0));
    look(2, IDLE);
    window(IND, ETR, 4'h6, AX);
    look(1, rec_of(0, 1, 4'h7));
    look(2, rec_of(0, 0, 4'h6));
    look(2, IDLE);
    $display("test faulting jump done");
    window(EXC, 7'h00, 4'h2, AX);
    look(1, IDLE);
    window(EXC, ETR, 4'h8, AX);
    look(1, rec_of(0, 1, 4'h7));
    look(2, rec_of(0, 0, 4'h8));
    $display("test back to back done");
    // reset in the middle of an address transfer must leave nothing behind
    window(7'h00, IND, 4'h0, AY);
    look(1, rec_of(0, 1, 4'hb));
    @(posedge mclk_in);
    srst_in <= 1'b1;
    @(posedge mclk_in);
    @(negedge mclk_in);
    check(tr, IDLE);
    check({10'h0, bus_clk}, 11'h0);
    @(posedge mclk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    do @(negedge mclk_in); while (bus_clk !== 1'b1);
    @(posedge mclk_in);
    window(7'h00, 7'h00, 4'h0, AY);
    look(1, IDLE);
    look(2, IDLE);
    window(P0 | P1, P0 | P1, 4'h0, AY);
    look(1, rec_of(6'h3c, 0, 4'h0));
    look(2, IDLE);
    $display("test mid-run reset done");
    test_done();
  end
endmodule
